// file: hw/microword_defs.svh
// Register offsets, reset values and field codes of the microword datapath
`ifndef MICROWORD_DEFS_SVH
`define MICROWORD_DEFS_SVH

`define ADDR_W          8
`define REG_CTRL        8'h00
`define REG_STATUS      8'h04
`define REG_COUNT       8'h08
`define REG_WORK_A      8'h0C
`define REG_WORK_B      8'h10
`define REG_MDR_MAIN    8'h14
`define REG_MDR_TAG     8'h18
`define CTRL_RUN_BIT    0
`define CTRL_RST        1'b1

`define CNT_INC         3'b011
`define CNT_HOLD        3'b111
`define WA_INC_LOW      3'b010
`define WA_INC_ALL      3'b011
`define WA_LOAD_MEM     3'b110
`define WA_HOLD         3'b111
`define SPA_SPARE       4'b1011
`define OUT_HALF_CODE   4'b0100

`endif

// file: hw/microword_pkg.sv
// Types shared by the microword datapath decoder
package microword_pkg;

  typedef enum logic [1:0] {
    MEM_IDLE  = 2'b00,
    MEM_READ  = 2'b01,
    MEM_BUF   = 2'b10,
    MEM_WRITE = 2'b11
  } mem_cycle_t;

  typedef enum logic [1:0] {
    ST_IDLE    = 2'b00,
    ST_RD_WAIT = 2'b01,
    ST_RD_DONE = 2'b10,
    ST_WR_RUN  = 2'b11
  } mem_state_t;

  // Bit 0 of each field except mem_ctrl is its leading (most significant) bit
  typedef struct packed {
    logic [0:2] count_reg_ctrl;
    logic [0:2] work_a_ctrl;
    logic [0:3] work_b_ctrl;
    logic [0:1] addr_src_sel;
    logic [0:1] data_src_sel;
    logic       addr_switch_sel;
    logic       result_half_sel_one;
    logic       result_half_sel_two;
    logic       scratch_wr;
    mem_cycle_t mem_ctrl;
    logic [0:5] scratch_addr_field;
    logic       second_bus_sel;
    logic [0:4] mem_out_sel_field;
    logic [0:7] arith_ctrl_field;
  } microword_t;

  typedef struct packed {
    logic busy;
    logic data_avail;
    logic data_accepted;
  } mem_status_t;

  typedef struct packed {
    logic        drive_hi;
    logic        drive_lo;
    logic [0:35] word;
  } mem_out_t;

endpackage

// file: hw/microword_datapath_decode.sv
// Microword field decoder and datapath with memory interlock and APB access
// Contract
// - count_reg load, shift, increment, hold codes
// - work_reg_a load, shift, increment codes
// - work_reg_b source select then shift
// - bus source selectors, switch, second operand
// - result bus bytes from data or arithmetic
// - scratch write from result bus when set
// - memory cycle codes read write buffer idle
// - read waits for data, advances after
// - later read or write halts while busy
// - write issues, sequence continues, reload after
// - buffer load takes external ports next edge
// - idle cycle starts nothing, holds buffers
// - leading scratch bit gives direct address
// - indirect scratch address selection table
// - fallback scratch address from data register
// - memory output word selector and halfword
// - sixteen bitwise functions, memory complemented
// - opcode bits select logical function
// - arithmetic operand pair selection
// - carry in and carry across control
// - output polarity and carry hold flag
// - add subtract step with end-around carry
`timescale 1ns/1ps
`default_nettype none
`include "microword_defs.svh"

module microword_datapath_decode (
  input  wire logic                       pclk,
  input  wire logic                       presetn,
  input  wire logic                       psel,
  input  wire logic                       penable,
  input  wire logic                       pwrite,
  input  wire logic [`ADDR_W-1:0]         paddr,
  input  wire logic [31:0]                pwdata,
  output logic      [31:0]                prdata,
  output logic                            pready,
  output logic                            pslverr,
  input  wire microword_pkg::microword_t  uword,
  input  wire logic                       uword_valid,
  output logic                            step_done,
  output logic                            clock_halted,
  input  wire microword_pkg::mem_status_t mem_status,
  input  wire logic [0:35]                mem_rdata,
  input  wire logic [0:35]                buf_data_in,
  input  wire logic [0:15]                buf_addr_in,
  output logic                            mem_rd_start,
  output logic                            mem_wr_start,
  output logic      [0:15]                mem_addr,
  output microword_pkg::mem_out_t         mem_out,
  input  wire logic [0:7]                 opcode_reg,
  input  wire logic [0:3]                 scratch_field_reg,
  input  wire logic [0:4]                 indirect_scratch_field,
  input  wire logic                       halfword_select_flag,
  input  wire logic                       opcode_sign_extract,
  input  wire logic                       scratch_sign,
  input  wire logic [0:35]                control_panel,
  input  wire logic [0:31]                aux_port_one,
  input  wire logic [0:31]                aux_port_two,
  input  wire logic [0:35]                channel_in
);

  microword_pkg::mem_state_t state_r;
  logic [0:15] count_reg_r, work_reg_a_r, work_reg_b_r, mem_addr_r;
  logic [0:35] memory_data_reg_r;
  logic [0:15] scratch_file [0:31];
  logic        carry_hold_flag_r, run_en_r, step_go, stall, issue_rd, issue_wr;
  logic [0:15] addr_source_bus, addr_switched, data_source_bus, memory_bus;
  logic [0:15] second_operand_bus, arith_output, result_bus, scratch_rd;
  logic [0:4]  scratch_addr;
  logic        arith_cout, arith_active;
  microword_pkg::mem_out_t out_nxt;

  // Doc bit 0 sits at the MSB of a [15:0] view
  function automatic logic [16:0] add16(input logic [15:0] x, input logic [15:0] y,
                                        input logic cin, input logic across,
                                        input logic c7_val);
    logic [8:0] lo;
    logic [8:0] hi;
    logic       c7;
    lo = {1'b0, x[7:0]} + {1'b0, y[7:0]} + {8'h00, cin};
    c7 = across ? lo[8] : c7_val;
    hi = {1'b0, x[15:8]} + {1'b0, y[15:8]} + {8'h00, c7};
    return {hi, lo[7:0]};
  endfunction

  // Index bit picked per bit position by the operand pair
  function automatic logic [0:15] logic16(input logic [3:0] idx, input logic [0:15] r1,
                                          input logic [0:15] r2);
    logic [0:15] f;
    for (int i = 0; i < 16; i++) begin
      f[i] = idx[{r1[i], r2[i]}];
    end
    return f;
  endfunction

  function automatic logic [0:15] pick_src(input logic [0:1] sel, input logic [0:15] wb,
                                           input logic [0:15] sp, input logic [0:15] cnt,
                                           input logic [0:15] wa);
    case (sel)
      2'b00:   return wb;
      2'b01:   return sp;
      2'b10:   return cnt;
      default: return wa;
    endcase
  endfunction

  // Source buses; switched form swaps the two bytes
  always_comb begin
    scratch_rd      = scratch_file[scratch_addr];
    addr_source_bus = pick_src(uword.addr_src_sel, work_reg_b_r, scratch_rd, count_reg_r,
                               work_reg_a_r);
    addr_switched   = uword.addr_switch_sel ? {addr_source_bus[8:15], addr_source_bus[0:7]}
                                            : addr_source_bus;
    data_source_bus = pick_src(uword.data_src_sel, work_reg_b_r, scratch_rd, count_reg_r,
                               work_reg_a_r);
    // Sign extraction only on the register-field addressing path
    if (!uword.scratch_addr_field[0] && !uword.scratch_addr_field[1]
        && memory_data_reg_r[13:15] == 3'b000 && uword.scratch_addr_field[5]
        && opcode_sign_extract && uword.data_src_sel == 2'b01) begin
      data_source_bus[0:7] = {8{data_source_bus[8]}};
    end
    memory_bus         = memory_data_reg_r[0:15];
    second_operand_bus = uword.second_bus_sel ? addr_switched : memory_bus;
  end

  // Scratch address generation
  always_comb begin
    scratch_addr = 5'h00;
    if (uword.scratch_addr_field[0]) begin
      scratch_addr = uword.scratch_addr_field[1:5];
    end else if (!uword.scratch_addr_field[1]) begin
      scratch_addr = (memory_data_reg_r[13:15] == 3'b000)
                   ? {1'b0, memory_data_reg_r[8:11]}
                   : {2'b00, memory_data_reg_r[13:15]};
    end else begin
      case (uword.scratch_addr_field[1:4])
        4'b1000: scratch_addr = memory_data_reg_r[23:27];
        4'b1001: scratch_addr = control_panel[0:4];
        4'b1010: scratch_addr = {1'b0, scratch_field_reg};
        4'b1100: scratch_addr = indirect_scratch_field;
        4'b1101: scratch_addr = indirect_scratch_field;
        4'b1110: scratch_addr = {1'b1, scratch_field_reg};
        4'b1111: scratch_addr = {2'b00, memory_data_reg_r[29:31]};
        default: scratch_addr = 5'h00; // Spare code reads word zero
      endcase
    end
  end

  // Arithmetic and logic unit
  always_comb begin
    logic [0:7]  a;
    logic [0:15] r1, r2, x, y, mem_op;
    logic [16:0] t, s;
    logic        sub, mem_sign, cin;
    a = uword.arith_ctrl_field;
    r1 = data_source_bus;
    r2 = uword.second_bus_sel ? second_operand_bus : ~memory_bus;
    mem_op = second_operand_bus;
    x = 16'h0000;
    y = 16'h0000;
    t = 17'h00000;
    s = 17'h00000;
    arith_output = 16'h0000;
    arith_cout = 1'b0;
    arith_active = 1'b0;
    mem_sign = (opcode_reg[5] & halfword_select_flag) ? memory_data_reg_r[16]
                                                        : memory_data_reg_r[0];
    sub = scratch_sign ^ mem_sign ^ opcode_reg[7];
    cin = (a[1:3] == 3'b001) ? carry_hold_flag_r : a[3];
    if (a[4] && a[1:3] == 3'b000) begin
      arith_active = 1'b1;
      if (sub) begin
        t = add16(mem_op, ~r1, 1'b0, 1'b1, 1'b0);
        s = add16(mem_op, ~r1, t[16], 1'b1, 1'b0);
        arith_output = t[16] ? s[15:0] : ~s[15:0];
        arith_cout = t[16];
      end else begin
        s = add16(mem_op, r1, 1'b0, 1'b1, 1'b0);
        arith_output = s[15:0];
        arith_cout = s[16];
      end
    end else if (a[4]) begin
      arith_active = 1'b1;
      case (a[5:7])
        3'b000:  begin x = ~r2;       y = 16'hFFFF; end
        3'b010:  begin x = 16'hFFFF;  y = 16'h0000; end
        3'b011:  begin x = r1;        y = 16'h0000; end
        3'b100:  begin x = 16'hFFFF;  y = 16'hFFFF; end
        3'b101:  begin x = r1;        y = 16'hFFFF; end
        3'b110:  begin x = r2;        y = 16'hFFFF; end
        default: begin x = r2;        y = r1;       end
      endcase
      s = add16(x, y, cin, ~a[1], a[2]);
      arith_cout = s[16];
      arith_output = a[0] ? s[15:0] : ~s[15:0];
    end else if (a[3]) begin
      arith_output = logic16({a[0], a[5], a[6], a[7]}, r1, r2);
    end else if (a[1] || a[2]) begin
      arith_output = logic16({opcode_reg[2], opcode_reg[3], opcode_reg[6], opcode_reg[7]},
                             r1, r2);
    end
    // Byte halves of the result bus
    result_bus[0:7]  = uword.result_half_sel_one ? arith_output[0:7] : data_source_bus[0:7];
    result_bus[8:15] = uword.result_half_sel_two ? arith_output[8:15]
                                                 : data_source_bus[8:15];
  end

  // Memory interlock: decides whether this step may retire
  always_comb begin
    issue_rd = 1'b0;
    issue_wr = 1'b0;
    stall    = 1'b0;
    case (uword.mem_ctrl)
      microword_pkg::MEM_READ: begin
        if (state_r == microword_pkg::ST_RD_DONE) begin
          stall = 1'b0;
        end else if (state_r == microword_pkg::ST_IDLE && !mem_status.busy) begin
          issue_rd = 1'b1;
          stall = 1'b1;
        end else begin
          stall = 1'b1;
        end
      end
      microword_pkg::MEM_WRITE: begin
        stall = mem_status.busy || state_r == microword_pkg::ST_RD_WAIT
             || state_r == microword_pkg::ST_WR_RUN;
        issue_wr = !stall;
      end
      microword_pkg::MEM_BUF: begin
        // Buffers stay put until the running cycle has taken them
        stall = state_r == microword_pkg::ST_RD_WAIT
             || state_r == microword_pkg::ST_WR_RUN;
      end
      default: stall = 1'b0;
    endcase
  end

  assign step_go = uword_valid && run_en_r && !stall;

  // Memory cycle state
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r <= microword_pkg::ST_IDLE;
    end else begin
      case (state_r)
        microword_pkg::ST_IDLE: begin
          if (uword_valid && run_en_r && issue_rd) begin
            state_r <= microword_pkg::ST_RD_WAIT;
          end else if (step_go && issue_wr) begin
            state_r <= microword_pkg::ST_WR_RUN;
          end
        end
        microword_pkg::ST_RD_WAIT: begin
          if (mem_status.data_avail) begin
            state_r <= microword_pkg::ST_RD_DONE;
          end
        end
        microword_pkg::ST_RD_DONE: begin
          if (step_go) begin
            state_r <= microword_pkg::ST_IDLE;
          end
        end
        microword_pkg::ST_WR_RUN: begin
          if (mem_status.data_accepted) begin
            state_r <= microword_pkg::ST_IDLE;
          end
        end
        default: state_r <= microword_pkg::ST_IDLE;
      endcase
    end
  end

  // Memory strobes and step handshake
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mem_rd_start <= 1'b0;
      mem_wr_start <= 1'b0;
      step_done    <= 1'b0;
      clock_halted <= 1'b0;
    end else begin
      mem_rd_start <= uword_valid && run_en_r && issue_rd;
      mem_wr_start <= step_go && issue_wr;
      step_done    <= step_go;
      clock_halted <= uword_valid && run_en_r && stall;
    end
  end

  // Data register and address buffer
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      memory_data_reg_r <= 36'h000000000;
      mem_addr_r        <= 16'h0000;
    end else begin
      if (state_r == microword_pkg::ST_RD_WAIT && mem_status.data_avail) begin
        memory_data_reg_r <= mem_rdata;
      end else if (step_go && uword.mem_ctrl == microword_pkg::MEM_BUF) begin
        memory_data_reg_r <= buf_data_in;
      end
      if (step_go && uword.mem_ctrl == microword_pkg::MEM_BUF) begin
        mem_addr_r <= buf_addr_in;
      end
    end
  end
  assign mem_addr = mem_addr_r;

  // Working registers; all move on the same retiring edge
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count_reg_r       <= 16'h0000;
      work_reg_a_r      <= 16'h0000;
      carry_hold_flag_r <= 1'b0;
    end else if (step_go) begin
      case (uword.count_reg_ctrl[1:2])
        2'b00: count_reg_r <= result_bus;
        2'b01: count_reg_r <= {addr_source_bus[0], count_reg_r[0:14]};
        2'b10: count_reg_r <= memory_bus;
        default: begin
          if (uword.count_reg_ctrl == `CNT_INC) begin
            count_reg_r <= count_reg_r + 16'h0001;
          end
        end
      endcase
      case (uword.work_a_ctrl)
        `WA_INC_LOW:  work_reg_a_r[8:15] <= work_reg_a_r[8:15] + 8'h01;
        `WA_INC_ALL:  work_reg_a_r <= work_reg_a_r + 16'h0001;
        `WA_LOAD_MEM: work_reg_a_r <= memory_bus;
        `WA_HOLD:     work_reg_a_r <= work_reg_a_r;
        default: begin
          if (uword.work_a_ctrl[2]) begin
            work_reg_a_r <= {result_bus[0], result_bus[0:14]};
          end else begin
            work_reg_a_r <= result_bus;
          end
        end
      endcase
      if (arith_active) begin
        carry_hold_flag_r <= arith_cout;
      end
    end
  end

  // Work register B: selector feeding the shifter
  always_ff @(posedge pclk or negedge presetn) begin
    logic [0:15] src;
    if (!presetn) begin
      work_reg_b_r <= 16'h0000;
    end else if (step_go) begin
      case (uword.work_b_ctrl[0:1])
        2'b00:   src = work_reg_b_r;
        2'b01:   src = memory_bus;
        2'b10:   src = 16'h0000;
        default: src = result_bus;
      endcase
      case (uword.work_b_ctrl[2:3])
        2'b01:   work_reg_b_r <= {src[1:15], 1'b0};
        2'b10:   work_reg_b_r <= {1'b0, src[0:14]};
        2'b11:   work_reg_b_r <= src;
        default: work_reg_b_r <= work_reg_b_r; // Unused code holds
      endcase
    end
  end

  // Scratch file write port
  always_ff @(posedge pclk) begin
    if (step_go && uword.scratch_wr) begin
      scratch_file[scratch_addr] <= result_bus;
    end
  end

  // Memory output word selector
  always_comb begin
    logic [0:3]  tag;
    logic [0:15] hi_h, lo_h;
    tag  = 4'h0;
    hi_h = memory_data_reg_r[0:15];
    lo_h = memory_data_reg_r[16:31];
    if (uword.arith_ctrl_field[4]) begin
      tag = {1'b0, uword.arith_ctrl_field[5:7]};
    end else if (uword.arith_ctrl_field[5]) begin
      tag = memory_data_reg_r[32:35];
    end else begin
      tag = 4'h0;
    end
    out_nxt.drive_hi = 1'b1;
    out_nxt.drive_lo = 1'b1;
    case (uword.mem_out_sel_field[0:3])
      4'b0000: out_nxt.word = {result_bus, lo_h, tag};
      4'b0001: out_nxt.word = {aux_port_one, tag};
      4'b0010: out_nxt.word = {aux_port_two, tag};
      4'b0011: out_nxt.word = {16'h0000, memory_data_reg_r[17:31], 1'b0, tag};
      4'b0101: out_nxt.word = {hi_h, hi_h, memory_data_reg_r[32:35]};
      4'b0110: out_nxt.word = {hi_h, result_bus, tag};
      4'b0111: out_nxt.word = {hi_h, 12'h000, memory_data_reg_r[32:35], tag};
      4'b1000: out_nxt.word = {16'h0000, lo_h, tag};
      4'b1010: out_nxt.word = {16'h0000, result_bus, tag};
      4'b1100: out_nxt.word = {hi_h, lo_h, result_bus[12:15]};
      4'b1101: out_nxt.word = {32'h00000000, tag};
      4'b1110: out_nxt.word = control_panel;
      4'b1111: out_nxt.word = channel_in;
      4'b1001, 4'b1011: out_nxt.word = {32'h00000000, tag};
      default: out_nxt.word = {hi_h, lo_h, memory_data_reg_r[32:35]};
    endcase
    // Halfword selection uses the clear fifth bit with code 010x
    if (uword.mem_out_sel_field[0:2] == 3'b010 && !uword.mem_out_sel_field[4]) begin
      out_nxt.word[16:31] = halfword_select_flag ? lo_h : hi_h;
    end
    // High-impedance upper half: drive_hi low, drive_lo low only with bit 3 set, data zero
    if (uword.mem_out_sel_field[0:1] == 2'b10) begin
      out_nxt.drive_hi = 1'b0;
      out_nxt.drive_lo = !uword.mem_out_sel_field[3];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mem_out <= '0;
    end else begin
      mem_out <= out_nxt;
    end
  end

  // APB slave: zero wait, read data captured in setup cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      run_en_r <= `CTRL_RST;
      prdata   <= 32'h00000000;
      pready   <= 1'b0;
      pslverr  <= 1'b0;
    end else begin
      pready <= 1'b1;
      if (psel && penable && pwrite && paddr == `REG_CTRL) begin
        run_en_r <= pwdata[`CTRL_RUN_BIT];
      end
      if (psel && !penable) begin
        pslverr <= 1'b0;
        case (paddr)
          `REG_CTRL:     prdata <= {31'h00000000, run_en_r};
          `REG_STATUS:   prdata <= {28'h0000000, clock_halted, state_r, carry_hold_flag_r};
          `REG_COUNT:    prdata <= {16'h0000, count_reg_r};
          `REG_WORK_A:   prdata <= {16'h0000, work_reg_a_r};
          `REG_WORK_B:   prdata <= {16'h0000, work_reg_b_r};
          `REG_MDR_MAIN: prdata <= memory_data_reg_r[0:31];
          `REG_MDR_TAG:  prdata <= {28'h0000000, memory_data_reg_r[32:35]};
          default: begin
            prdata  <= 32'h00000000;
            pslverr <= 1'b1;
          end
        endcase
      end
    end
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  count_hold_a: assert property (step_go && uword.count_reg_ctrl == `CNT_HOLD
    |=> count_reg_r == $past(count_reg_r)) else $error("count_reg changed on hold");
  count_inc_a: assert property (step_go && uword.count_reg_ctrl == `CNT_INC
    |=> count_reg_r == $past(count_reg_r) + 16'h0001) else $error("count_reg not incremented");
  work_a_low_a: assert property (step_go && uword.work_a_ctrl == `WA_INC_LOW
    |=> work_reg_a_r[0:7] == $past(work_reg_a_r[0:7])) else $error("upper byte moved");
  work_b_clear_a: assert property (step_go && uword.work_b_ctrl == 4'b1011
    |=> work_reg_b_r == 16'h0000) else $error("work_reg_b not cleared");
  result_pass_a: assert property (!uword.result_half_sel_one && !uword.result_half_sel_two
    |-> result_bus == data_source_bus) else $error("result bus not data source");
  read_hold_a: assert property (state_r == microword_pkg::ST_RD_WAIT
    |-> !step_go) else $error("step retired before read data");
  busy_halt_a: assert property (uword_valid && run_en_r && mem_status.busy
    && (uword.mem_ctrl == microword_pkg::MEM_WRITE
        || (uword.mem_ctrl == microword_pkg::MEM_READ
            && state_r != microword_pkg::ST_RD_DONE))
    |=> clock_halted && !step_done)
    else $error("memory request passed a busy memory");
  write_go_a: assert property (step_go && uword.mem_ctrl == microword_pkg::MEM_WRITE
    |=> mem_wr_start && step_done ##1 !mem_wr_start) else $error("write did not continue");
  buf_load_a: assert property (step_go && uword.mem_ctrl == microword_pkg::MEM_BUF
    |=> memory_data_reg_r == $past(buf_data_in) && mem_addr_r == $past(buf_addr_in))
    else $error("buffer load missed");
  scratch_direct_a: assert property (uword.scratch_addr_field[0]
    |-> scratch_addr == uword.scratch_addr_field[1:5]) else $error("direct scratch address");

endmodule

`default_nettype wire

// file: sim/mem_partner.sv
// Main memory partner answering read and write starts
`timescale 1ns/1ps
`default_nettype none
module mem_partner #(
  parameter int          LAT  = 3,
  parameter logic [0:35] DATA = 36'h987654321
) (
  input  wire logic                  pclk,
  input  wire logic                  presetn,
  input  wire logic                  mem_rd_start,
  input  wire logic                  mem_wr_start,
  output microword_pkg::mem_status_t mem_status,
  output logic [0:35]                mem_rdata
);
  int   cnt;
  logic rd;
  // Busy for LAT cycles after a start, then one answer pulse
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt <= 0;
      rd <= 1'b0;
      mem_status <= '0;
    end else begin
      mem_status.data_avail <= 1'b0;
      mem_status.data_accepted <= 1'b0;
      if (mem_rd_start || mem_wr_start) begin
        cnt <= LAT;
        rd <= mem_rd_start;
        mem_status.busy <= 1'b1;
      end else if (cnt == 1) begin
        cnt <= 0;
        mem_status.busy <= 1'b0;
        mem_status.data_avail <= rd;
        mem_status.data_accepted <= !rd;
      end else if (cnt > 1) begin
        cnt <= cnt - 1;
      end
    end
  end
  // Data valid only with the answer; inverted otherwise so stale reads show
  assign mem_rdata = mem_status.data_avail ? DATA : ~DATA;
endmodule
`default_nettype wire

// file: sim/microword_datapath_decode_tb_top.sv
// Testbench for the microword datapath decoder
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, w) begin check_count++; if ((g) !== (w)) begin num_errors++; \
  $display("mismatch at %0t: got %h want %h", $time, g, w); end end
module microword_datapath_decode_tb_top;
  typedef struct {microword_pkg::microword_t u; logic [15:0] c, a, b;} row_t;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, uword_valid = 0;
  logic [7:0]  paddr = '0;
  logic [31:0] pwdata = '0, prdata, rd;
  logic        pready, pslverr, step_done, clock_halted, mem_rd_start, mem_wr_start, er;
  logic [0:15] mem_addr, buf_addr_in = 16'hA5A5;
  logic [0:35] mem_rdata, buf_data_in = '0, control_panel = 36'h1, channel_in = 36'h2;
  logic [0:31] aux_port_one = '1, aux_port_two = '0;
  logic [0:7]  opcode_reg = 8'h3C;
  logic [0:4]  indirect_scratch_field = 5'h03;
  logic [0:3]  scratch_field_reg = 4'h5;
  logic halfword_select_flag = 0, opcode_sign_extract = 0, scratch_sign = 0;
  microword_pkg::microword_t   uword;
  microword_pkg::mem_status_t  mem_status;
  microword_pkg::mem_out_t     mem_out;
  int   num_errors = 0, check_count = 0, halts;
  row_t rows[4];
  always #25 pclk = ~pclk;
  microword_datapath_decode dut_u (.*);
  mem_partner mem_u (.*);
  // Idle word with the given register and memory controls
  function automatic microword_pkg::microword_t mk(logic [0:2] c, logic [0:2] a,
      logic [0:3] b, microword_pkg::mem_cycle_t m);
    mk = '0;
    {mk.count_reg_ctrl, mk.work_a_ctrl, mk.work_b_ctrl, mk.mem_ctrl} = {c, a, b, m};
    mk.scratch_addr_field = 6'h20;
    mk.mem_out_sel_field = 5'h01;
  endfunction
  // One APB transfer; request held until pready is seen
  task automatic apb(input logic w, input logic [7:0] a);
    @(posedge pclk);
    {psel, penable, pwrite, paddr} <= {1'b1, 1'b0, w, a};
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    {psel, penable} <= 2'b00;
  endtask
  // Step without interlock retires at its first edge
  task automatic step(input microword_pkg::microword_t u);
    @(posedge pclk);
    uword <= u;
    uword_valid <= 1'b1;
    @(posedge pclk);
    uword_valid <= 1'b0;
    do @(posedge pclk); while (step_done !== 1'b1);
  endtask
  // Read step held until data arrives, retires one edge later
  task automatic rstep();
    @(posedge pclk);
    uword <= mk(3'b111, 3'b111, 4'b0011, microword_pkg::MEM_READ);
    uword_valid <= 1'b1;
    halts = 0;
    do begin
      @(posedge pclk);
      if (clock_halted === 1'b1) halts++;
      if (mem_rd_start === 1'b1) `CHK(mem_status.busy, 1'b0)
    end while (mem_status.data_avail !== 1'b1);
    @(posedge pclk);
    uword_valid <= 1'b0;
    do @(posedge pclk); while (step_done !== 1'b1);
    `CHK(halts > 0, 1'b1)
  endtask
  task automatic wrap_up();
    $display("errors %0d checks %0d", num_errors, check_count);
    if (num_errors == 0 && check_count > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // Watchdog well beyond the expected run length
  initial begin
    repeat (5000) @(posedge pclk);
    num_errors++;
    wrap_up();
  end
  initial begin
    uword = mk(3'b111, 3'b111, 4'b0011, microword_pkg::MEM_IDLE);
    rows = '{'{mk(3'b010, 3'b110, 4'b0101, microword_pkg::MEM_IDLE), 16'h12FF, 16'h12FF, 16'h25FE},
             '{mk(3'b011, 3'b010, 4'b0110, microword_pkg::MEM_IDLE), 16'h1300, 16'h1200, 16'h097F},
             '{mk(3'b111, 3'b011, 4'b1010, microword_pkg::MEM_IDLE), 16'h1300, 16'h1201, 16'h0000},
             '{mk(3'b011, 3'b111, 4'b0011, microword_pkg::MEM_IDLE), 16'h1301, 16'h1201, 16'h0000}};
    repeat (4) @(posedge pclk);
    `CHK(pready, 1'b0)
    presetn <= 1'b1;
    buf_data_in <= 36'h12FF00005;
    step(mk(3'b111, 3'b111, 4'b0011, microword_pkg::MEM_BUF));
    `CHK(mem_addr, 16'hA5A5)
    apb(1'b0, 8'h14);
    `CHK(rd, 32'h12FF0000)
    foreach (rows[i]) begin
      step(rows[i].u);
      apb(1'b0, 8'h08);
      `CHK(rd[15:0], rows[i].c)
      apb(1'b0, 8'h0C);
      `CHK(rd[15:0], rows[i].a)
      apb(1'b0, 8'h10);
      `CHK(rd[15:0], rows[i].b)
    end
    // Read, then write, then a read that must wait for the write
    rstep();
    apb(1'b0, 8'h14);
    `CHK(rd, 32'h98765432)
    `CHK({mem_out.drive_hi, mem_out.drive_lo, mem_out.word}, {2'b11, 36'h000054320})
    step(mk(3'b111, 3'b111, 4'b0011, microword_pkg::MEM_WRITE));
    `CHK(mem_wr_start, 1'b1)
    rstep();
    apb(1'b0, 8'hFC);
    `CHK({er, rd}, 33'h0_0000_0000 | 33'h1_0000_0000)
    // Mid-run reset clears registers; run enable comes back set
    presetn <= 1'b0;
    @(posedge pclk);
    `CHK({pready, step_done, clock_halted, mem_rd_start}, 4'b0000)
    presetn <= 1'b1;
    apb(1'b0, 8'h08);
    `CHK(rd, 32'h00000000)
    apb(1'b0, 8'h00);
    `CHK(rd, 32'h00000001)
    wrap_up();
  end
endmodule
`default_nettype wire
